// ### hw/mcct_pkg.sv
// Shared constants of the measurement clock and cycle timer.
// Assumes a single 100 MHz system clock and a simple register port.
package mcct_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_CYCLE = 8'h01; // Cycle length
    localparam logic [7:0] ADDR_OSC = 8'h07; // Oscillator and reference
    localparam logic [7:0] ADDR_STAT = 8'h10; // Sticky status and state
    localparam logic [7:0] ADDR_IEN = 8'h11; // Interrupt enable
    localparam logic [7:0] ADDR_ICLR = 8'h12; // Interrupt clear, write only

    // Field positions
    localparam int CYC_LSB = 12; // Cycle length bits 23..12
    localparam int CYC_W = 12;
    localparam int OSC_LSB = 0; // Oscillator control bits 1..0
    localparam int DIV_LSB = 2; // Divider bits 3..2
    localparam int REFSEL_BIT = 4; // Cycle reference select
    localparam int SINGLE_BIT = 5; // Single conversion select
    localparam int RANGE2_BIT = 6; // Measurement range 2
    localparam int STAT_BUSY_BIT = 4; // Busy flag in status
    localparam int STAT_IDX_LSB = 5; // Cycle index in status

    // Oscillator control codes
    localparam logic [1:0] OSC_OFF = 2'h0;
    localparam logic [1:0] OSC_RUN = 2'h1;
    localparam logic [1:0] OSC_SHORT = 2'h2;
    localparam logic [1:0] OSC_LONG = 2'h3;

    // Interrupt bit positions
    localparam int IRQ_TOUT = 0; // Discharge time-out
    localparam int IRQ_DONE = 1; // Halfbridge measurement done
    localparam int IRQ_W = 2;

    // Reset values
    localparam logic [11:0] CYC_LEN_RST = 12'h000;
    localparam logic [1:0] OSC_CTRL_RST = 2'h0;
    localparam logic [1:0] DIV_RST = 2'h0;

    // Cycles per halfbridge measurement, as last index
    localparam logic [2:0] LAST_CYCLE = 3'h7;

    // Timing
    localparam int CLK_MHZ = 100; // System clock rate
    localparam int SETTLE_SHORT_US = 640; // Short settling delay
    localparam int SETTLE_LONG_US = 1280; // Long settling delay
    localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_US * CLK_MHZ;
    localparam int SETTLE_LONG_CYC = SETTLE_LONG_US * CLK_MHZ;
    localparam int SETTLE_W = 17; // Holds the long count

    // Sequencer phases
    typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_DISCH, PH_RECH} mcct_phase_t;
endpackage : mcct_pkg

// ### hw/mcct_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes asynchronous pin inputs; outputs are registered.
module mcct_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins
    input wire logic [W-1:0] pin_i,
    // Filtered level and its rising pulse
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);
    // All state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1; // Only read by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
    } mcct_sync_state_t;

    mcct_sync_state_t q, d;

    // Next state; a level changes only once stages two and three agree
    always_comb
    begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (q.s2 & ~(q.s2 ^ q.s3)) | (q.lvl & (q.s2 ^ q.s3));
        d.rise = d.lvl & ~q.lvl;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
    assign rise_o = q.rise;
endmodule : mcct_sync

// ### hw/mcct_clk_div.sv
// Power-of-two divider of the fast reference ticks.
// Assumes tick_i is a one-cycle pulse per fast reference edge.
module mcct_clk_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick and ratio select
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    // Divided enable pulse
    output logic en_o
);
    // All state of the divider
    typedef struct packed {
        logic [2:0] cnt; // Ticks seen in this period
        logic en; // Registered enable
    } mcct_div_state_t;

    mcct_div_state_t q, d;
    logic [2:0] top; // Last count of a period

    // Divide by 1, 2, 4 or 8
    always_comb
    begin
        top = 3'(4'h1 << sel_i) - 3'h1;
        d = q;
        d.en = 1'b0;
        if (tick_i)
        begin
            if (q.cnt >= top)
            begin
                d.cnt = 3'h0;
                d.en = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 3'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign en_o = q.en;

    a_div_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.en && sel_i != 2'h0) |=> !q.en)
        else $error("Divided enable repeated too early");
endmodule : mcct_clk_div

// ### hw/mcct_top.sv
// Measurement clock control and cycle timer, top level.
// Assumes a 100 MHz clk_i, asynchronous reference, trigger and
// comparator pins, and a host on a plain one-cycle register port.
//
// Implementation choices: the register offsets and the address-and-strobe port.
module mcct_top #(
    parameter int SETTLE_SHORT_CYC = mcct_pkg::SETTLE_SHORT_CYC,
    parameter int SETTLE_LONG_CYC = mcct_pkg::SETTLE_LONG_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Start requests
    input wire logic start_i, // Start opcode, same clock
    input wire logic trigger_pin_i, // External trigger pin
    // Reference clock pins and comparator
    input wire logic fast_reference_clock_i,
    input wire logic slow_reference_clock_i,
    input wire logic comparator_i, // High once threshold reached
    // Oscillator and time digitizer
    output logic fast_osc_en_o,
    output logic time_digitizer_ref_en_o,
    // Sequencer status
    output logic busy_o,
    output logic discharge_o,
    output logic recharge_o,
    output logic [2:0] cycle_index_o,
    output logic meas_done_o,
    output logic timeout_o,
    // Interrupt
    output logic irq_o
);
    // All state of the block
    typedef struct packed {
        mcct_pkg::mcct_phase_t phase; // Sequencer phase
        logic [11:0] cyc_len; // cycle_length_count
        logic [1:0] osc_ctrl; // fast_osc_control
        logic [1:0] div_sel; // fast_clock_divider
        logic ref_sel; // cycle_reference_select
        logic single; // single_conversion_select
        logic range2; // Measurement range 2
        logic osc_on; // Oscillator enable
        logic [mcct_pkg::SETTLE_W-1:0] settle; // Settling counter
        logic [11:0] cnt; // Reference periods in cycle
        logic [2:0] idx; // Cycle within measurement
        logic [mcct_pkg::IRQ_W-1:0] stat; // Sticky events
        logic [mcct_pkg::IRQ_W-1:0] ien; // Interrupt enable
        logic [31:0] rdata; // Read data, one cycle late
        logic done_p; // Measurement done pulse
        logic tout_p; // Time-out pulse
    } mcct_state_t;

    mcct_state_t q, d;

    logic [3:0] pin_lvl; // Filtered pin levels
    logic [3:0] pin_rise; // Filtered rising pulses
    logic fast_tick; // Fast reference edge
    logic div_en; // Divided fast reference
    logic ref_tick; // Cycle reference period
    logic go; // Start request
    logic end_hit; // Cycle length reached
    logic [mcct_pkg::SETTLE_W-1:0] settle_top; // Last settling count
    logic [mcct_pkg::IRQ_W-1:0] ev; // Events this cycle
    logic [mcct_pkg::IRQ_W-1:0] clr; // Software clear mask

    // Pin synchronisers: trigger, comparator, fast and slow reference
    mcct_sync #(
        .W(4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({slow_reference_clock_i, fast_reference_clock_i,
                comparator_i, trigger_pin_i}),
        .level_o(pin_lvl),
        .rise_o(pin_rise)
    );

    // Fast edges count only while the oscillator is enabled
    assign fast_tick = pin_rise[2] & q.osc_on;

    // Fast clock divider feeding digitizer and cycle timer
    mcct_clk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(fast_tick),
        .sel_i(q.div_sel),
        .en_o(div_en)
    );

    // Reference choice; range 2 forces the fast clock
    assign ref_tick = (q.ref_sel && !q.range2) ? pin_rise[3] : div_en;

    // Start by opcode or trigger
    assign go = start_i | pin_rise[0];

    // End of cycle; a zero length ends at once
    assign end_hit = (q.cyc_len == 12'h000) ||
        (ref_tick && ({1'b0, q.cnt} + 13'h0001 >= {1'b0, q.cyc_len}));

    // Settling length for the chosen code
    assign settle_top = (q.osc_ctrl == mcct_pkg::OSC_LONG) ?
        mcct_pkg::SETTLE_W'(SETTLE_LONG_CYC - 1) :
        mcct_pkg::SETTLE_W'(SETTLE_SHORT_CYC - 1);

    // Next state: registers, sequencer, oscillator, status
    always_comb
    begin
        d = q;
        d.done_p = 1'b0;
        d.tout_p = 1'b0;
        d.rdata = 32'h0000_0000;
        ev = '0;
        clr = '0;

        // Register writes
        if (wr_i)
        begin
            case (addr_i)
                mcct_pkg::ADDR_CYCLE:
                begin
                    d.cyc_len = wdata_i[mcct_pkg::CYC_LSB +: mcct_pkg::CYC_W];
                end
                mcct_pkg::ADDR_OSC:
                begin
                    d.osc_ctrl = wdata_i[mcct_pkg::OSC_LSB +: 2];
                    d.div_sel = wdata_i[mcct_pkg::DIV_LSB +: 2];
                    d.ref_sel = wdata_i[mcct_pkg::REFSEL_BIT];
                    d.single = wdata_i[mcct_pkg::SINGLE_BIT];
                    d.range2 = wdata_i[mcct_pkg::RANGE2_BIT];
                end
                mcct_pkg::ADDR_IEN:
                begin
                    d.ien = wdata_i[mcct_pkg::IRQ_W-1:0];
                end
                mcct_pkg::ADDR_ICLR:
                begin
                    clr = wdata_i[mcct_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads; unmapped addresses read zero
        if (rd_i)
        begin
            case (addr_i)
                mcct_pkg::ADDR_CYCLE:
                begin
                    d.rdata[mcct_pkg::CYC_LSB +: mcct_pkg::CYC_W] = q.cyc_len;
                end
                mcct_pkg::ADDR_OSC:
                begin
                    d.rdata[mcct_pkg::OSC_LSB +: 2] = q.osc_ctrl;
                    d.rdata[mcct_pkg::DIV_LSB +: 2] = q.div_sel;
                    d.rdata[mcct_pkg::REFSEL_BIT] = q.ref_sel;
                    d.rdata[mcct_pkg::SINGLE_BIT] = q.single;
                    d.rdata[mcct_pkg::RANGE2_BIT] = q.range2;
                end
                mcct_pkg::ADDR_STAT:
                begin
                    d.rdata[mcct_pkg::IRQ_W-1:0] = q.stat;
                    d.rdata[mcct_pkg::STAT_BUSY_BIT] = (q.phase != mcct_pkg::PH_IDLE);
                    d.rdata[mcct_pkg::STAT_IDX_LSB +: 3] = q.idx;
                end
                mcct_pkg::ADDR_IEN:
                begin
                    d.rdata[mcct_pkg::IRQ_W-1:0] = q.ien;
                end
                default:
                begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Cycle counter advances on reference periods
        if (ref_tick && (q.phase == mcct_pkg::PH_DISCH || q.phase == mcct_pkg::PH_RECH))
        begin
            d.cnt = q.cnt + 12'h001;
        end

        // Measurement sequencer
        case (q.phase)
            mcct_pkg::PH_IDLE:
            begin
                // A stopped oscillator cannot time, so starts are ignored
                if (go && q.osc_ctrl != mcct_pkg::OSC_OFF)
                begin
                    d.cnt = 12'h000;
                    d.idx = 3'h0;
                    d.settle = '0;
                    if (q.osc_ctrl == mcct_pkg::OSC_RUN || q.osc_on)
                    begin
                        d.phase = mcct_pkg::PH_DISCH;
                    end
                    else
                    begin
                        d.phase = mcct_pkg::PH_SETTLE;
                    end
                end
            end
            mcct_pkg::PH_SETTLE:
            begin
                // Hold the start until the resonator has settled
                if (q.settle >= settle_top)
                begin
                    d.phase = mcct_pkg::PH_DISCH;
                    d.cnt = 12'h000;
                end
                else
                begin
                    d.settle = q.settle + 1'b1;
                end
            end
            mcct_pkg::PH_DISCH:
            begin
                // Discharge timing; comparator ends it
                if (pin_rise[1])
                begin
                    d.phase = mcct_pkg::PH_RECH;
                end
                else if (end_hit)
                begin
                    d.phase = mcct_pkg::PH_IDLE;
                    d.tout_p = 1'b1;
                    ev[mcct_pkg::IRQ_TOUT] = 1'b1;
                end
            end
            mcct_pkg::PH_RECH:
            begin
                // Rest of the cycle recharges the capacitor
                if (end_hit)
                begin
                    d.cnt = 12'h000;
                    if (q.idx == mcct_pkg::LAST_CYCLE)
                    begin
                        d.phase = mcct_pkg::PH_IDLE;
                        d.done_p = 1'b1;
                        ev[mcct_pkg::IRQ_DONE] = 1'b1;
                    end
                    else
                    begin
                        d.idx = q.idx + 3'h1;
                        d.phase = mcct_pkg::PH_DISCH;
                    end
                end
            end
            default:
            begin
                d.phase = mcct_pkg::PH_IDLE;
            end
        endcase

        // Oscillator enable; delayed codes outside single mode run freely
        d.osc_on = (q.osc_ctrl == mcct_pkg::OSC_RUN) ||
            (q.osc_ctrl[1] && (!q.single || d.phase != mcct_pkg::PH_IDLE));

        // Sticky status; an event beats a clear in the same cycle
        d.stat = (q.stat & ~clr) | ev;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.cyc_len <= mcct_pkg::CYC_LEN_RST;
            q.osc_ctrl <= mcct_pkg::OSC_CTRL_RST;
            q.div_sel <= mcct_pkg::DIV_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs
    assign rdata_o = q.rdata;
    assign fast_osc_en_o = q.osc_on;
    assign time_digitizer_ref_en_o = div_en;
    assign busy_o = (q.phase != mcct_pkg::PH_IDLE);
    assign discharge_o = (q.phase == mcct_pkg::PH_DISCH);
    assign recharge_o = (q.phase == mcct_pkg::PH_RECH);
    assign cycle_index_o = q.idx;
    assign meas_done_o = q.done_p;
    assign timeout_o = q.tout_p;
    assign irq_o = |(q.stat & q.ien);

    // Checks
    a_osc_off_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.osc_ctrl == mcct_pkg::OSC_OFF) |=> !fast_osc_en_o)
        else $error("Oscillator runs while control is off");

    a_osc_run_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.osc_ctrl == mcct_pkg::OSC_RUN) |=> fast_osc_en_o)
        else $error("Oscillator stopped while control is run");

    a_run_no_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && go && q.osc_ctrl == mcct_pkg::OSC_RUN) |=> discharge_o)
        else $error("Continuous mode start was delayed");

    a_settle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.phase == mcct_pkg::PH_SETTLE && q.settle < settle_top)
        |=> q.phase == mcct_pkg::PH_SETTLE)
        else $error("Settling ended early");

    a_long_settle: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.phase == mcct_pkg::PH_SETTLE && q.osc_ctrl == mcct_pkg::OSC_LONG && $stable(q.osc_ctrl)
        && q.settle == mcct_pkg::SETTLE_W'(SETTLE_LONG_CYC - 1)) |=> discharge_o)
        else $error("Long settling did not end on time");

    a_short_settle: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.phase == mcct_pkg::PH_SETTLE && q.osc_ctrl == mcct_pkg::OSC_SHORT
        && q.settle == mcct_pkg::SETTLE_W'(SETTLE_SHORT_CYC - 1)) |=> discharge_o)
        else $error("Short settling did not end on time");

    a_single_idle_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && q.osc_ctrl[1] && q.single && !go) |=> !fast_osc_en_o)
        else $error("Oscillator runs between single conversions");

    a_range2_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        q.range2 |-> (ref_tick == div_en))
        else $error("Range 2 not timed by fast clock");

    a_eight_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_done_o |-> ($past(q.idx) == mcct_pkg::LAST_CYCLE && $past(recharge_o)))
        else $error("Measurement done before eight cycles");

    a_timeout_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        timeout_o |-> ($past(discharge_o) && !busy_o && q.stat[mcct_pkg::IRQ_TOUT]))
        else $error("Time-out without pending discharge");

    a_cycle_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(recharge_o) && discharge_o) |-> (q.cnt == 12'h000 &&
        ({1'b0, $past(q.cnt)} + 13'h0001 >= {1'b0, $past(q.cyc_len)})))
        else $error("Cycle did not restart at programmed length");
endmodule : mcct_top

// ### verification/mcct_analog_model.sv
// Model of the analog side: fast and slow reference pins and comparator.
// Assumes the 100 MHz bench clock; reference rates are scaled down.
module mcct_analog_model (
    // Clock and controls
    input wire logic clk_i,
    input wire logic osc_en_i,
    input wire logic discharge_i,
    input wire logic [7:0] dly_i, // Discharge length, 0 never ends
    // Pins
    output logic fast_clk_o,
    output logic slow_clk_o,
    output logic comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0; // Free-running cycle count
    int d = 0; // Cycles into discharge
    initial
    begin
        fast_clk_o = 1'b0;
        slow_clk_o = 1'b0;
        comp_o = 1'b0;
    end
    // Period 8 keeps the pin steady long enough for the sync filter
    always @(posedge clk_i)
    begin
        n <= n + 1;
        fast_clk_o <= osc_en_i && (n % 8 >= 4); // Stands low while off
        slow_clk_o <= (n % 64 >= 32); // Free running slow reference
        d <= discharge_i ? d + 1 : 0;
        comp_o <= discharge_i && dly_i != 8'h00 && d >= int'(dly_i); // Threshold crossing
    end
endmodule : mcct_analog_model

// ### verification/tb.sv
// Self-checking bench of the measurement clock and cycle timer.
// Assumes the analog model drives reference pins and the comparator.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wr_i, rd_i, start_i, trigger_pin_i;
    logic [7:0] addr_i, dly;
    logic [31:0] wdata_i, rdata_o, rd_val;
    logic fast_reference_clock_i, slow_reference_clock_i, comparator_i;
    logic fast_osc_en_o, time_digitizer_ref_en_o, busy_o, discharge_o;
    logic recharge_o, meas_done_o, timeout_o, irq_o, osc_before;
    logic [2:0] cycle_index_o;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0; // Hang guard count
    int gap, ndis, nrec, nto, lat, ndone; // Results of the last run
    // Short settling counts keep the run brief
    mcct_top #(.SETTLE_SHORT_CYC(20), .SETTLE_LONG_CYC(40)) uut (.clk_i, .rst_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .start_i, .trigger_pin_i, .fast_reference_clock_i,
        .slow_reference_clock_i, .comparator_i, .fast_osc_en_o, .time_digitizer_ref_en_o,
        .busy_o, .discharge_o, .recharge_o, .cycle_index_o, .meas_done_o, .timeout_o, .irq_o);
    mcct_analog_model model (.clk_i(clk_i), .osc_en_i(fast_osc_en_o),
        .discharge_i(discharge_o), .dly_i(dly), .fast_clk_o(fast_reference_clock_i),
        .slow_clk_o(slow_reference_clock_i), .comp_o(comparator_i));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Cuts a hang short
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask : rd
    task automatic irq_is(input logic e);
        @(posedge clk_i);
        #1 chk(irq_o, e, "irq");
    endtask : irq_is
    function automatic logic [31:0] cfg(input logic [1:0] c, input logic [1:0] d,
        input logic s, input logic r2, input logic one);
        return {25'h0, r2, one, s, d, c};
    endfunction : cfg
    // One measurement: counts discharge and recharge starts and time-outs
    task automatic run(input logic [31:0] c7, input logic [11:0] len, input logic [7:0] d,
        input bit trig);
        bit pd, pr;
        int t0;
        pd = 0;
        pr = 0;
        t0 = 0;
        {gap, ndis, nrec, nto, lat, ndone} = '0;
        dly <= d;
        wr(mcct_pkg::ADDR_CYCLE, {8'h00, len, 12'h000});
        wr(mcct_pkg::ADDR_OSC, c7);
        repeat (3) @(posedge clk_i);
        #1 osc_before = fast_osc_en_o;
        @(posedge clk_i);
        if (trig)
            trigger_pin_i <= 1'b1;
        else
            start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (int n = 1; n < 9000; n++)
        begin
            #1;
            if (discharge_o === 1'b1 && !pd)
            begin
                if (ndis == 0)
                    lat = n;
                // First cycle starts off the reference phase, so time a full one
                if (ndis == 2)
                    gap = n - t0;
                t0 = n;
                ndis++;
            end
            nrec += (recharge_o === 1'b1 && !pr);
            nto += (timeout_o === 1'b1);
            ndone += (meas_done_o === 1'b1);
            pd = (discharge_o === 1'b1);
            pr = (recharge_o === 1'b1);
            if (ndis > 0 && busy_o === 1'b0)
                break;
            @(posedge clk_i);
            if (n == 8)
                trigger_pin_i <= 1'b0;
        end
    endtask : run
    task automatic t_regs();
        rd(mcct_pkg::ADDR_CYCLE);
        chk(rd_val, 32'h0000_0000, "cycle reset");
        rd(mcct_pkg::ADDR_OSC);
        chk(rd_val, 32'h0000_0000, "osc reset");
        chk(fast_osc_en_o, 1'b0, "osc off");
        // A start with the oscillator stopped must be ignored
        @(posedge clk_i);
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        @(posedge clk_i);
        #1 chk(busy_o, 1'b0, "start refused");
        chk(time_digitizer_ref_en_o, 1'b0, "no fast ticks");
        wr(mcct_pkg::ADDR_CYCLE, 32'h00AB_C000);
        rd(8'h20);
        chk(rd_val, 32'h0000_0000, "unmapped");
        rd(mcct_pkg::ADDR_CYCLE);
        chk(rd_val, 32'h00AB_C000, "cycle field");
        wr(mcct_pkg::ADDR_OSC, 32'h0000_0001);
        irq_is(1'b0);
        chk(fast_osc_en_o, 1'b1, "osc on");
        $display("test registers done");
    endtask : t_regs
    task automatic t_div();
        for (int d = 0; d < 4; d++)
        begin
            run(cfg(mcct_pkg::OSC_RUN, d[1:0], 1'b0, 1'b0, 1'b0), 12'h003, 8'h06, 1'b0);
            chk(gap, 24 << d, "cycle length");
            chk(ndis, 8, "cycles");
            chk(ndone, 1, "done pulse");
            chk(cycle_index_o, 3'h7, "last index");
            chk(nrec, 8, "recharges");
            chk(lat, 1, "start delay");
            chk(osc_before, 1'b1, "osc running");
        end
        $display("test dividers done");
    endtask : t_div
    task automatic t_ref();
        run(cfg(mcct_pkg::OSC_RUN, 2'h0, 1'b1, 1'b0, 1'b0), 12'h002, 8'h06, 1'b0);
        chk(gap, 128, "slow reference");
        run(cfg(mcct_pkg::OSC_RUN, 2'h0, 1'b1, 1'b1, 1'b0), 12'h003, 8'h06, 1'b0);
        chk(gap, 24, "range two");
        run(cfg(mcct_pkg::OSC_RUN, 2'h0, 1'b0, 1'b0, 1'b0), 12'h003, 8'h06, 1'b1);
        chk(ndis, 8, "trigger start");
        $display("test references done");
    endtask : t_ref
    task automatic t_irq();
        wr(mcct_pkg::ADDR_IEN, 32'h0000_0003);
        run(cfg(mcct_pkg::OSC_RUN, 2'h0, 1'b0, 1'b0, 1'b0), 12'h002, 8'h00, 1'b0);
        chk(nto, 1, "timeouts");
        chk(ndis, 1, "abandoned");
        chk(ndone, 0, "no done");
        rd(mcct_pkg::ADDR_STAT);
        chk(rd_val[0], 1'b1, "timeout status");
        irq_is(1'b1);
        wr(mcct_pkg::ADDR_ICLR, 32'h0000_0003);
        irq_is(1'b0);
        run(cfg(mcct_pkg::OSC_RUN, 2'h0, 1'b0, 1'b0, 1'b0), 12'h003, 8'h06, 1'b0);
        irq_is(1'b1);
        wr(mcct_pkg::ADDR_IEN, 32'h0000_0000);
        irq_is(1'b0);
        wr(mcct_pkg::ADDR_IEN, 32'h0000_0002);
        irq_is(1'b1);
        wr(mcct_pkg::ADDR_ICLR, 32'h0000_0003);
        irq_is(1'b0);
        $display("test interrupts done");
    endtask : t_irq
    task automatic t_settle();
        int w;
        for (int k = 0; k < 2; k++)
        begin
            w = k ? 40 : 20;
            // Delayed codes only with slow reference and single conversion
            run(cfg(k ? mcct_pkg::OSC_LONG : mcct_pkg::OSC_SHORT, 2'h0, 1'b1, 1'b0, 1'b1),
                12'h002, 8'h06, 1'b0);
            chk(osc_before, 1'b0, "idle osc");
            chk(lat >= w && lat <= w + 3, 1'b1, "settle time");
            chk(ndis, 8, "settled cycles");
            repeat (2) @(posedge clk_i);
            #1 chk(fast_osc_en_o, 1'b0, "osc stopped");
        end
        $display("test settling done");
    endtask : t_settle
    initial
    begin
        rst_i = 1'b1;
        {wr_i, rd_i, start_i, trigger_pin_i} = 4'h0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        dly = 8'h06;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_div();
        t_ref();
        t_irq();
        t_settle();
        conclude();
    end
endmodule : tb
